// File: design/icc_defines.svh
// Offsets, field positions, reset values and counts of the instruction cache controller
`ifndef ICC_DEFINES_SVH
`define ICC_DEFINES_SVH

`define ICC_OFF_CTRL 12'h000
`define ICC_OFF_STATUS 12'h004
`define ICC_OFF_HITCNT 12'h008

`define ICC_CTRL_CFG_LSB 0
`define ICC_CTRL_CFG_MSB 1
`define ICC_CTRL_EN_BIT 2
`define ICC_CTRL_FLUSH_BIT 3

`define ICC_STAT_BUSY_BIT 0
`define ICC_STAT_TYPE_LSB 1
`define ICC_STAT_TYPE_MSB 2

`define ICC_CTRL_CFG_RST 2'h2
`define ICC_CTRL_EN_RST 1'b1

`define ICC_ENTRIES 2048
`define ICC_IDX_W 11
`define ICC_FLUSH_ADDR 23'h7fff80

`define ICC_FC_USER_DATA 3'h1
`define ICC_FC_USER_PROG 3'h2
`define ICC_FC_SUP_DATA 3'h5
`define ICC_FC_SUP_PROG 3'h6

`endif

// File: design/icc_pkg.sv
// Types shared by the instruction cache controller
package icc_pkg;

  typedef enum logic [1:0] {
    CFG_USER  = 2'h0,
    CFG_SUP   = 2'h1,
    CFG_MIXED = 2'h2,
    CFG_SPLIT = 2'h3
  } icc_cfg_t;

  typedef enum logic [1:0] {
    CYC_IGNORE     = 2'h0,
    CYC_HIT        = 2'h1,
    CYC_VALIDATE   = 2'h2,
    CYC_INVALIDATE = 2'h3
  } icc_cyc_t;

  typedef enum logic [2:0] {
    ST_IDLE     = 3'h0,
    ST_LOOK     = 3'h1,
    ST_CLASS    = 3'h2,
    ST_HIT      = 3'h3,
    ST_WAIT_DEV = 3'h4,
    ST_WAIT_END = 3'h5
  } icc_state_t;

  typedef struct packed {
    logic valid_bit_a;
    logic valid_bit_b;
    logic space;
    logic [12:0] tag;
    logic [15:0] data;
  } icc_entry_t;

  typedef struct packed {
    logic [23:1] addr;
    logic [2:0] fc;
    logic rd;
  } icc_req_t;

endpackage

// File: design/icc_store.sv
// Entry array of the instruction cache with one read and one write port
`timescale 1ns/1ps
`include "icc_defines.svh"

module icc_store #(
  parameter int ENTRIES = `ICC_ENTRIES,
  parameter int IDX_W = `ICC_IDX_W
) (
  input wire logic i_clk,
  input wire logic [IDX_W-1:0] i_rd_idx,
  input wire logic i_wr_en,
  input wire logic [IDX_W-1:0] i_wr_idx,
  input wire icc_pkg::icc_entry_t i_wr_entry,
  output icc_pkg::icc_entry_t o_rd_entry
);

  icc_pkg::icc_entry_t mem_r [ENTRIES];
  icc_pkg::icc_entry_t rd_r;

  assign o_rd_entry = rd_r;

  always_ff @(posedge i_clk) begin
    rd_r <= mem_r[i_rd_idx];
    if (i_wr_en) begin
      mem_r[i_wr_idx] <= i_wr_entry;
    end
  end

endmodule

// File: design/icc_classify.sv
// Classifies one processor memory access against the indexed entry
`timescale 1ns/1ps
`include "icc_defines.svh"

module icc_classify (
  input icc_pkg::icc_req_t i_req,
  input icc_pkg::icc_entry_t i_entry,
  input icc_pkg::icc_cfg_t i_cfg,
  input wire logic i_enable,
  output icc_pkg::icc_cyc_t o_cyc
);

  logic valid;
  logic tag_match;
  logic space_on;

  always_comb begin
    valid = i_entry.valid_bit_a & i_entry.valid_bit_b;
    // Bit A11 belongs to the tag only when it is not part of the index
    if (i_cfg == icc_pkg::CFG_SPLIT) begin
      tag_match = (i_entry.tag == i_req.addr[23:11]);
    end else begin
      tag_match = (i_entry.tag[12:1] == i_req.addr[23:12]);
    end
    case (i_cfg)
      icc_pkg::CFG_USER: space_on = ~i_req.fc[2];
      icc_pkg::CFG_SUP: space_on = i_req.fc[2];
      default: space_on = 1'b1;
    endcase
    o_cyc = icc_pkg::CYC_IGNORE;
    case (i_req.fc)
      `ICC_FC_USER_PROG, `ICC_FC_SUP_PROG: begin
        if (i_enable && space_on && i_req.rd) begin
          if (valid && tag_match && (i_entry.space == i_req.fc[2])) begin
            o_cyc = icc_pkg::CYC_HIT;
          end else begin
            o_cyc = icc_pkg::CYC_VALIDATE;
          end
        end
      end
      `ICC_FC_USER_DATA: begin
        if (!i_req.rd && valid && tag_match && !i_entry.space) begin
          o_cyc = icc_pkg::CYC_INVALIDATE;
        end
      end
      `ICC_FC_SUP_DATA: begin
        if (!i_req.rd && valid && tag_match && i_entry.space) begin
          o_cyc = icc_pkg::CYC_INVALIDATE;
        end
      end
      default: o_cyc = icc_pkg::CYC_IGNORE;
    endcase
    // Data reads fall through to ignore above
    if (i_req.rd && !i_req.fc[1]) begin
      o_cyc = icc_pkg::CYC_IGNORE;
    end
  end

endmodule

// File: design/icc_ctrl.sv
// Instruction cache cycle control with its APB register file
`timescale 1ns/1ps
`include "icc_defines.svh"

module icc_ctrl #(
  parameter logic [23:1] FLUSH_ADDR = `ICC_FLUSH_ADDR
) (
  input wire logic I_CLK,
  input wire logic I_NRST,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [11:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  input wire logic I_ACC_START,
  input wire logic I_ACC_END,
  input wire logic I_FOREIGN_CYC,
  input wire logic [23:1] I_ADDR,
  input wire logic [2:0] I_FC,
  input wire logic I_RD,
  input wire logic I_DEV_ACK,
  input wire logic [15:0] I_DEV_DATA,
  output logic O_SEL_EN,
  output logic [15:0] O_DATA,
  output logic O_DATA_OE,
  output logic O_DTACK_N,
  output logic O_HIT_N
);

  // ****************************************************************
  // Registers
  // ****************************************************************
  icc_pkg::icc_cfg_t cfg_r, cfg_nxt;
  logic en_r, en_nxt;
  logic flush_req;
  logic [31:0] hitcnt_r, hitcnt_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic slverr_r, slverr_nxt;
  icc_pkg::icc_cyc_t last_r, last_nxt;
  logic setup;
  logic wr_acc;
  logic mapped;
  logic ctrl_wr;

  assign setup = I_PSEL & ~I_PENABLE;
  assign wr_acc = I_PSEL & I_PENABLE & I_PWRITE;
  assign mapped = (I_PADDR == `ICC_OFF_CTRL) || (I_PADDR == `ICC_OFF_STATUS) ||
                  (I_PADDR == `ICC_OFF_HITCNT);
  assign ctrl_wr = wr_acc && (I_PADDR == `ICC_OFF_CTRL);
  // Flush is a write-one pulse: it never stays set in the register
  assign flush_req = ctrl_wr && I_PWDATA[`ICC_CTRL_FLUSH_BIT];
  assign O_PREADY = 1'b1;
  assign O_PRDATA = prdata_r;
  assign O_PSLVERR = slverr_r & I_PSEL & I_PENABLE;

  // ****************************************************************
  // Cycle state
  // ****************************************************************
  icc_pkg::icc_state_t st_r, st_nxt;
  icc_pkg::icc_req_t req_r, req_nxt;
  icc_pkg::icc_cyc_t cyc;
  icc_pkg::icc_entry_t rd_entry;
  icc_pkg::icc_entry_t wr_entry;
  logic [15:0] data_r, data_nxt;
  logic flushing_r, flushing_nxt;
  logic [`ICC_IDX_W-1:0] fidx_r, fidx_nxt;
  logic [`ICC_IDX_W-1:0] idx;
  logic wr_en;
  logic [`ICC_IDX_W-1:0] wr_idx;

  // Index from low address, bank from privilege code bit when split
  function automatic logic [`ICC_IDX_W-1:0] index_of(input icc_pkg::icc_req_t r,
                                                     input icc_pkg::icc_cfg_t c);
    if (c == icc_pkg::CFG_SPLIT) begin
      index_of = {r.fc[2], r.addr[10:1]};
    end else begin
      index_of = r.addr[11:1];
    end
  endfunction

  assign idx = index_of(req_r, cfg_r);

  icc_classify u_classify (
    .i_req(req_r),
    .i_entry(rd_entry),
    .i_cfg(cfg_r),
    .i_enable(en_r),
    .o_cyc(cyc)
  );

  icc_store u_store (
    .i_clk(I_CLK),
    .i_rd_idx(idx),
    .i_wr_en(wr_en),
    .i_wr_idx(wr_idx),
    .i_wr_entry(wr_entry),
    .o_rd_entry(rd_entry)
  );

  always_comb begin
    st_nxt = st_r;
    req_nxt = req_r;
    data_nxt = data_r;
    last_nxt = last_r;
    flushing_nxt = flushing_r;
    fidx_nxt = fidx_r;
    wr_en = 1'b0;
    wr_idx = idx;
    wr_entry = rd_entry;
    if (flushing_r) begin
      // One entry per clock is cleared while the walk runs
      wr_en = 1'b1;
      wr_idx = fidx_r;
      wr_entry = '0;
      fidx_nxt = fidx_r + `ICC_IDX_W'(1);
      if (fidx_r == {`ICC_IDX_W{1'b1}}) begin
        flushing_nxt = 1'b0;
      end
    end
    case (st_r)
      icc_pkg::ST_IDLE: begin
        if (I_ACC_START && !I_FOREIGN_CYC) begin
          req_nxt.addr = I_ADDR;
          req_nxt.fc = I_FC;
          req_nxt.rd = I_RD;
          st_nxt = icc_pkg::ST_LOOK;
        end
      end
      // The store reads on this edge, so the entry is seen in CLASS
      icc_pkg::ST_LOOK: st_nxt = icc_pkg::ST_CLASS;
      icc_pkg::ST_CLASS: begin
        if (flushing_r || (req_r.addr == FLUSH_ADDR)) begin
          last_nxt = icc_pkg::CYC_IGNORE;
          st_nxt = icc_pkg::ST_WAIT_END;
        end else begin
          last_nxt = cyc;
          case (cyc)
            icc_pkg::CYC_HIT: begin
              data_nxt = rd_entry.data;
              st_nxt = icc_pkg::ST_HIT;
            end
            icc_pkg::CYC_VALIDATE, icc_pkg::CYC_INVALIDATE: st_nxt = icc_pkg::ST_WAIT_DEV;
            default: st_nxt = icc_pkg::ST_WAIT_END;
          endcase
        end
        if (req_r.addr == FLUSH_ADDR) begin
          flushing_nxt = 1'b1;
          fidx_nxt = '0;
        end
      end
      icc_pkg::ST_HIT: begin
        if (I_ACC_END) begin
          st_nxt = icc_pkg::ST_IDLE;
        end
      end
      icc_pkg::ST_WAIT_DEV: begin
        // An access that ends before the device answers leaves the entry as it was
        if (I_ACC_END) begin
          st_nxt = icc_pkg::ST_IDLE;
        end else if (I_DEV_ACK) begin
          st_nxt = icc_pkg::ST_WAIT_END;
          if (!flushing_r) begin
            wr_en = 1'b1;
            wr_idx = idx;
            if (last_r == icc_pkg::CYC_VALIDATE) begin
              wr_entry.data = I_DEV_DATA;
              wr_entry.tag = req_r.addr[23:11];
              wr_entry.space = req_r.fc[2];
              wr_entry.valid_bit_a = 1'b1;
              wr_entry.valid_bit_b = 1'b1;
            end else begin
              wr_entry.valid_bit_a = 1'b0;
              wr_entry.valid_bit_b = 1'b0;
            end
          end
        end
      end
      icc_pkg::ST_WAIT_END: begin
        if (I_ACC_END) begin
          st_nxt = icc_pkg::ST_IDLE;
        end
      end
      default: st_nxt = icc_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      st_r <= icc_pkg::ST_IDLE;
      req_r <= '0;
      data_r <= 16'h0000;
      last_r <= icc_pkg::CYC_IGNORE;
      // The array is unknown after reset, so a full walk always follows
      flushing_r <= 1'b1;
      fidx_r <= '0;
    end else begin
      st_r <= st_nxt;
      req_r <= req_nxt;
      data_r <= data_nxt;
      last_r <= last_nxt;
      // A new flush request wins over the end of a running walk
      flushing_r <= flushing_nxt | flush_req;
      fidx_r <= flush_req ? '0 : fidx_nxt;
    end
  end

  // ****************************************************************
  // Hit counter
  // ****************************************************************
  // Counts classified hits only, so flushes and a disabled cache add nothing
  always_comb begin
    hitcnt_nxt = hitcnt_r;
    if ((st_r == icc_pkg::ST_CLASS) && (st_nxt == icc_pkg::ST_HIT)) begin
      hitcnt_nxt = hitcnt_r + 32'h1;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      hitcnt_r <= 32'h00000000;
    end else begin
      hitcnt_r <= hitcnt_nxt;
    end
  end

  // ****************************************************************
  // Processor side outputs
  // ****************************************************************
  always_comb begin
    O_SEL_EN = (st_r == icc_pkg::ST_WAIT_DEV) || (st_r == icc_pkg::ST_WAIT_END);
    O_DATA = data_r;
    O_DATA_OE = (st_r == icc_pkg::ST_HIT);
    O_DTACK_N = ~(st_r == icc_pkg::ST_HIT);
    O_HIT_N = ~((st_r == icc_pkg::ST_HIT) && (last_r == icc_pkg::CYC_HIT));
  end

  // ****************************************************************
  // APB register access
  // ****************************************************************
  always_comb begin
    cfg_nxt = cfg_r;
    en_nxt = en_r;
    prdata_nxt = prdata_r;
    slverr_nxt = slverr_r;
    // Read data is latched in setup so the access phase needs no wait
    if (setup) begin
      slverr_nxt = ~mapped;
      prdata_nxt = 32'h00000000;
      case (I_PADDR)
        `ICC_OFF_CTRL: begin
          prdata_nxt[`ICC_CTRL_CFG_MSB:`ICC_CTRL_CFG_LSB] = cfg_r;
          prdata_nxt[`ICC_CTRL_EN_BIT] = en_r;
        end
        `ICC_OFF_STATUS: begin
          prdata_nxt[`ICC_STAT_BUSY_BIT] = flushing_r;
          prdata_nxt[`ICC_STAT_TYPE_MSB:`ICC_STAT_TYPE_LSB] = last_r;
        end
        `ICC_OFF_HITCNT: prdata_nxt = hitcnt_r;
        default: prdata_nxt = 32'h00000000;
      endcase
    end
    if (ctrl_wr) begin
      cfg_nxt = icc_pkg::icc_cfg_t'(I_PWDATA[`ICC_CTRL_CFG_MSB:`ICC_CTRL_CFG_LSB]);
      en_nxt = I_PWDATA[`ICC_CTRL_EN_BIT];
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      cfg_r <= icc_pkg::icc_cfg_t'(`ICC_CTRL_CFG_RST);
      en_r <= `ICC_CTRL_EN_RST;
      prdata_r <= 32'h00000000;
      slverr_r <= 1'b0;
    end else begin
      cfg_r <= cfg_nxt;
      en_r <= en_nxt;
      prdata_r <= prdata_nxt;
      slverr_r <= slverr_nxt;
    end
  end

endmodule

// File: dv/icc_chk.sv
// Port assertions of the instruction cache controller
`timescale 1ns/1ps
module icc_chk (
  input wire logic I_CLK,
  input wire logic I_NRST,
  input wire logic I_ACC_START,
  input wire logic I_ACC_END,
  input wire logic I_FOREIGN_CYC,
  input wire logic [2:0] I_FC,
  input wire logic I_RD,
  input wire logic O_SEL_EN,
  input wire logic [15:0] O_DATA,
  input wire logic O_DATA_OE,
  input wire logic O_DTACK_N,
  input wire logic O_HIT_N
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_NRST);
  logic act_r;
  logic act_nxt;
  wire go = I_ACC_START && !act_r && !I_FOREIGN_CYC;
  wire quiet = !O_SEL_EN && O_DTACK_N;
  // Open from an accepted start until the end strobe
  always_comb begin
    act_nxt = act_r;
    if (go)
      act_nxt = 1'b1;
    else if (I_ACC_END)
      act_nxt = 1'b0;
  end
  always_ff @(posedge I_CLK) begin
    if (!I_NRST)
      act_r <= 1'b0;
    else
      act_r <= act_nxt;
  end
  AST_IDLE: assert property (!act_r |-> quiet) else $error("bus driven off access");
  AST_LAT: assert property (go |=> quiet [*2] ##1 !quiet) else $error("bad latency");
  AST_HIT: assert property (!O_DTACK_N |-> !O_SEL_EN && O_DATA_OE && !O_HIT_N)
    else $error("hit outputs mixed");
  AST_HOLD: assert property (!O_DTACK_N && !I_ACC_END |=> !O_DTACK_N && $stable(O_DATA))
    else $error("hit data moved");
  AST_SEL: assert property (O_SEL_EN && !I_ACC_END |=> O_SEL_EN) else $error("select lost");
  AST_END: assert property (act_r && I_ACC_END |=> quiet ##1 quiet)
    else $error("no release");
  AST_DREAD: assert property (go && I_RD && I_FC inside {3'h1, 3'h5} |=> ##2 O_SEL_EN)
    else $error("data read cached");
  AST_FOREIGN: assert property (I_FOREIGN_CYC && !act_r |=> quiet [*3])
    else $error("acted in foreign cycle");
endmodule
bind icc_ctrl icc_chk chk_i (.I_CLK, .I_NRST, .I_ACC_START, .I_ACC_END, .I_FOREIGN_CYC, .I_FC,
  .I_RD, .O_SEL_EN, .O_DATA, .O_DATA_OE, .O_DTACK_N, .O_HIT_N);

// File: dv/icc_dev.sv
// Selected memory device answering after a set delay
`timescale 1ns/1ps
module icc_dev (
  input wire logic clk,
  input wire logic nrst,
  input wire logic sel,
  input wire logic [23:1] adr,
  input wire logic [1:0] dly,
  output logic ack,
  output logic [15:0] dat
);
  logic [2:0] cnt;
  logic done;
  always @(posedge clk) begin
    ack <= 1'b0;
    if (ack)
      dat <= ~dat;
    if (!nrst || !sel) begin
      cnt <= 3'h0;
      done <= 1'b0;
      if (!nrst)
        dat <= 16'h0;
    end else if (!done && cnt == {1'b0, dly}) begin
      ack <= 1'b1;
      done <= 1'b1;
      dat <= adr[16:1] ^ {adr[23:17], 9'h0a5};
    end else
      cnt <= cnt + 3'h1;
  end
endmodule

// File: dv/icc_ctrl_bench.sv
// Self-checking bench of the instruction cache controller
`timescale 1ns/1ps
module icc_ctrl_bench;
  logic clk = 0, nrst = 0, psel = 0, pen = 0, pwr = 0, st = 0, fin = 0, frn = 0, rd = 0;
  logic ack, sel, doe, dtn, hitn, prdy, perr, x, sq = 0, dq = 1;
  logic [11:0] pa = 0;
  logic [31:0] pwd = 0, prd, r;
  logic [23:1] adr = 0, a;
  logic [2:0] fc = 0;
  logic [1:0] dly = 0;
  logic [15:0] dd, od;
  logic [16:0] eq[$];
  logic [16:0] e;
  logic [7:0] tt[4] = '{8'h91, 8'h08, 8'h9a, 8'h99};
  int n_errors = 0, checks = 0, cyc = 0, seed = 6406, nhit = 0;
  always #2 clk = ~clk;
  icc_ctrl dut (.I_CLK(clk), .I_NRST(nrst), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
    .I_PADDR(pa), .I_PWDATA(pwd), .O_PRDATA(prd), .O_PREADY(prdy), .O_PSLVERR(perr),
    .I_ACC_START(st), .I_ACC_END(fin), .I_FOREIGN_CYC(frn), .I_ADDR(adr), .I_FC(fc),
    .I_RD(rd), .I_DEV_ACK(ack), .I_DEV_DATA(dd), .O_SEL_EN(sel), .O_DATA(od),
    .O_DATA_OE(doe), .O_DTACK_N(dtn), .O_HIT_N(hitn));
  icc_dev dev (.clk(clk), .nrst(nrst), .sel(sel), .adr(adr), .dly(dly), .ack(ack), .dat(dd));
  function automatic logic [15:0] pd(input logic [23:1] v);
    return v[16:1] ^ {v[23:17], 9'h0a5};
  endfunction
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] w);
    checks++;
    if (s !== w) begin
      n_errors++;
      $display("BAD %s exp %h got %h", nm, w, s);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic rst;
    nrst <= 0;
    repeat (16) @(posedge clk);
    nrst <= 1;
  endtask
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    pwr <= w;
    pa <= ad;
    pwd <= d;
    @(posedge clk);
    pen <= 1;
    do @(posedge clk); while (prdy !== 1'b1);
    r = prd;
    x = perr;
    psel <= 0;
    pen <= 0;
  endtask
  task automatic fl;
    do apb(0, 12'h004, 0); while (r[0] !== 1'b0);
  endtask
  // Hit expectation goes to the monitor, cycle type is read back
  task automatic acc(input logic [23:1] v, input logic [2:0] f, input logic w,
                     input logic [1:0] ty);
    eq.push_back({ty == 2'h1, pd(v)});
    if (ty == 2'h1)
      nhit++;
    @(posedge clk);
    st <= 1;
    adr <= v;
    fc <= f;
    rd <= w;
    dly <= 2'($random(seed));
    @(posedge clk);
    st <= 0;
    while (!sel && dtn) @(posedge clk);
    if (sel)
      while (!ack) @(posedge clk);
    fin <= 1;
    @(posedge clk);
    fin <= 0;
    apb(0, 12'h004, 0);
    chk("type", r[2:1], ty);
  endtask
  always @(posedge clk) begin
    sq <= sel;
    dq <= dtn;
    if ((sel && !sq) || (!dtn && dq)) begin
      chk("queue", eq.size() > 0, 1);
      e = eq.pop_front();
      chk("hit", !hitn, e[16]);
      chk("oe", doe, e[16]);
      if (e[16])
        chk("data", od, e[15:0]);
    end
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      n_errors++;
      summarize();
    end
  end
  initial begin
    rst();
    fl();
    apb(0, 12'h000, 0);
    chk("ctrl", r, 32'h6);
    apb(0, 12'h008, 0);
    chk("hitcnt", r, 0);
    apb(1, 12'h010, 32'h5);
    chk("err", x, 1);
    apb(0, 12'h010, 0);
    chk("unmapped", r, 0);
    $display("registers done");
    a = 23'h012345;
    for (int c = 0; c < 4; c++) begin
      apb(1, 12'h000, 32'hc | c);
      fl();
      acc(a, 3'h2, 1, tt[c][7:6]);
      acc(a, 3'h2, 1, tt[c][5:4]);
      acc(a, 3'h6, 1, tt[c][3:2]);
      acc(a, 3'h2, 1, tt[c][1:0]);
    end
    $display("modes done");
    apb(1, 12'h000, 32'he);
    fl();
    acc(a, 3'h2, 1, 2);
    acc(a, 3'h1, 1, 0);
    acc(a, 3'h5, 0, 0);
    acc(a, 3'h2, 1, 1);
    acc(a, 3'h1, 0, 3);
    acc(a, 3'h2, 1, 2);
    acc(a, 3'h6, 1, 2);
    acc(a, 3'h5, 1, 0);
    acc(a, 3'h1, 0, 0);
    acc(a, 3'h5, 0, 3);
    acc(a ^ 23'h800, 3'h2, 1, 2);
    apb(1, 12'h000, 32'h2);
    acc(a ^ 23'h800, 3'h2, 1, 0);
    apb(1, 12'h000, 32'h6);
    $display("classes done");
    @(posedge clk);
    frn <= 1;
    st <= 1;
    adr <= a ^ 23'h2;
    @(posedge clk);
    st <= 0;
    repeat (6) @(posedge clk);
    frn <= 0;
    acc(a ^ 23'h2, 3'h2, 1, 2);
    repeat (6) begin
      a = 23'($random(seed)) & 23'h3fffff;
      acc(a, 3'h2, 1, 2);
      acc(a, 3'h2, 1, 1);
    end
    acc(23'h7fff80, 3'h2, 1, 0);
    acc(a, 3'h2, 1, 0);
    fl();
    acc(a, 3'h2, 1, 2);
    apb(0, 12'h008, 0);
    chk("hitcnt", r, nhit);
    rst();
    fl();
    acc(a, 3'h2, 1, 2);
    $display("flush done");
    summarize();
  end
endmodule
